// file: deadband_delay.sv
`default_nettype none
module deadband_delay (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic raw_i,
    input wire logic [6:0] count_i,
    output logic out_o
);
    logic [6:0] cnt_reg;

    // delayed rising edge, immediate falling edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 7'h00;
            out_o <= 1'b0;
        end else if (!raw_i) begin
            cnt_reg <= 7'h00;
            out_o <= 1'b0;
        end else if (!out_o) begin
            if (cnt_reg >= count_i) begin
                out_o <= 1'b1;
            end else if (tick_i) begin
                cnt_reg <= cnt_reg + 7'h01;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    fall_no_delay_a: assert property ($fell(raw_i) |=> !out_o)
        else $error("falling edge was delayed");
    zero_count_a: assert property (raw_i && !out_o && count_i == 7'h00 ##1 raw_i |-> out_o)
        else $error("zero count delayed the edge");
    early_edge_a: assert property (!raw_i ##1 (raw_i && count_i != 7'h00) |=> !out_o)
        else $error("active edge came without delay");
endmodule // deadband_delay
`default_nettype wire

// file: pwm_steer_pkg.sv
`default_nettype none
package pwm_steer_pkg;
    // byte offsets on the register bus
    localparam logic [7:0] OFF_RESTART = 8'h00;
    localparam logic [7:0] OFF_STEER = 8'h04;
    localparam logic [7:0] OFF_UNIT = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_DIR = 8'h10;
    // field positions
    localparam int STAT_EVENT_BIT = 0;
    localparam int STAT_LEVEL_BIT = 1;
    localparam int STAT_RUN_BIT = 2;
    // reset values
    localparam logic [7:0] RST_RESTART = 8'h00;
    localparam logic [4:0] RST_STEER = 5'h01;
    localparam logic [7:0] RST_UNIT = 8'h00;
    localparam logic [3:0] RST_DIR = 4'hF;
    // mode values that select single output with steering
    localparam logic [1:0] MODE_UPPER_PWM = 2'h3;
    localparam logic [1:0] CFG_SINGLE = 2'h0;
    // oscillator periods per instruction cycle
    localparam int TCY_OSC = 4;
    localparam logic [1:0] TCY_LAST = 2'(TCY_OSC - 1);
    // level driven on a steered pin during shutdown
    localparam logic SHUT_LEVEL = 1'b0;

    typedef struct packed {
        logic auto_restart_enable;
        logic [6:0] deadband_delay_count;
    } restart_deadband_t;

    typedef struct packed {
        logic steer_update_sync;
        logic steer_enable_d;
        logic steer_enable_c;
        logic steer_enable_b;
        logic steer_enable_a;
    } steer_t;

    typedef struct packed {
        logic [1:0] output_config_select;
        logic [1:0] duty_low_bits;
        logic [1:0] unit_mode_upper;
        logic [1:0] output_polarity_select;
    } unit_ctrl_t;
endpackage
`default_nettype wire

// file: pwm_steering_restart_control.sv
// The implementer's own choices: the Wishbone slave port and the address map.
`default_nettype none
module pwm_steering_restart_control (
    input wire logic clk_i,
    input wire logic rst_i,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // scheduled waveform from the period and duty generator
    input wire logic pwm_raw_i,
    input wire logic period_start_i,
    // shutdown condition level, asynchronous
    input wire logic shutdown_i,
    // port data for pins not steered
    input wire logic [3:0] port_data_i,
    // pins: index 0 is pwm_out_a up to 3 for pwm_out_d
    output logic [3:0] pin_out_o,
    output logic [3:0] pin_oe_n_o
);
    pwm_steer_pkg::restart_deadband_t rd_reg;
    pwm_steer_pkg::steer_t steer_reg;
    pwm_steer_pkg::unit_ctrl_t unit_reg;
    logic [3:0] dir_reg;
    logic [3:0] steer_eff_reg;
    logic pending_reg;
    logic shutdown_event_status;
    logic run_reg;
    logic [1:0] div_reg;
    logic tcy_tick;
    logic sd_meta_reg;
    logic sd_sync_reg;
    logic pwm_delayed;
    logic wb_req;
    logic wb_wr;
    logic steer_active;
    logic [31:0] rd_data;

    // inversion for pin idx: pins a,c use bit 1, pins b,d use bit 0
    function automatic logic pin_invert(input logic [1:0] pol, input int idx);
        pin_invert = (idx % 2 == 0) ? pol[1] : pol[0];
    endfunction

    // write strobe for a given offset, low byte lane only
    function automatic logic wr_hit(input logic wr, input logic [7:0] adr,
                                    input logic [7:0] off);
        wr_hit = wr && (adr == off);
    endfunction

    // bus request decode, one access per ack
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];

    // steering mode gate
    assign steer_active = (unit_reg.unit_mode_upper == pwm_steer_pkg::MODE_UPPER_PWM)
        && (unit_reg.output_config_select == pwm_steer_pkg::CFG_SINGLE);

    // shutdown level synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sd_meta_reg <= 1'b0;
            sd_sync_reg <= 1'b0;
        end else begin
            sd_meta_reg <= shutdown_i;
            sd_sync_reg <= sd_meta_reg;
        end
    end

    // instruction cycle enable, one pulse every four clocks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
        end
    end
    assign tcy_tick = (div_reg == pwm_steer_pkg::TCY_LAST);

    // restart and dead-band control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_reg <= pwm_steer_pkg::RST_RESTART;
        end else if (wr_hit(wb_wr, wb_adr_i, pwm_steer_pkg::OFF_RESTART)) begin
            rd_reg <= wb_dat_i[7:0];
        end
    end

    // unit mode register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unit_reg <= pwm_steer_pkg::RST_UNIT;
        end else if (wr_hit(wb_wr, wb_adr_i, pwm_steer_pkg::OFF_UNIT)) begin
            unit_reg <= wb_dat_i[7:0];
        end
    end

    // pin direction register, 0 selects output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_reg <= pwm_steer_pkg::RST_DIR;
        end else if (wr_hit(wb_wr, wb_adr_i, pwm_steer_pkg::OFF_DIR)) begin
            dir_reg <= wb_dat_i[3:0];
        end
    end

    // steering register, only five bits stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            steer_reg <= pwm_steer_pkg::RST_STEER;
        end else if (wr_hit(wb_wr, wb_adr_i, pwm_steer_pkg::OFF_STEER)) begin
            steer_reg <= wb_dat_i[4:0];
        end
    end

    // pending update, raised by a steering write, dropped when applied
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending_reg <= 1'b0;
        end else if (wr_hit(wb_wr, wb_adr_i, pwm_steer_pkg::OFF_STEER)) begin
            pending_reg <= 1'b1;
        end else if (pending_reg && !steer_reg.steer_update_sync && tcy_tick) begin
            pending_reg <= 1'b0;
        end else if (pending_reg && steer_reg.steer_update_sync && period_start_i) begin
            pending_reg <= 1'b0;
        end
    end

    // effective steering enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            steer_eff_reg <= pwm_steer_pkg::RST_STEER[3:0];
        end else if (pending_reg && !steer_reg.steer_update_sync && tcy_tick) begin
            steer_eff_reg <= steer_reg[3:0];
        end else if (pending_reg && steer_reg.steer_update_sync && period_start_i) begin
            steer_eff_reg <= steer_reg[3:0];
        end
    end

    // shutdown event flag: set wins over every clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shutdown_event_status <= 1'b0;
        end else if (sd_sync_reg) begin
            shutdown_event_status <= 1'b1;
        end else if (wr_hit(wb_wr, wb_adr_i, pwm_steer_pkg::OFF_STATUS)) begin
            shutdown_event_status <= wb_dat_i[pwm_steer_pkg::STAT_EVENT_BIT];
        end else if (rd_reg.auto_restart_enable) begin
            shutdown_event_status <= 1'b0;
        end
    end

    // output run state, resumes only at a period start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_reg <= 1'b1;
        end else if (shutdown_event_status || sd_sync_reg) begin
            run_reg <= 1'b0;
        end else if (!run_reg && period_start_i) begin
            run_reg <= 1'b1;
        end
    end

    // dead-band delay on the scheduled waveform
    deadband_delay u_deadband (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tcy_tick),
        .raw_i(pwm_raw_i),
        .count_i(rd_reg.deadband_delay_count),
        .out_o(pwm_delayed)
    );

    // pin drivers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_out_o <= 4'h0;
            pin_oe_n_o <= 4'hF;
        end else begin
            for (int i = 0; i < 4; i++) begin
                pin_oe_n_o[i] <= dir_reg[i];
                if (steer_active && steer_eff_reg[i]) begin
                    if (!run_reg) begin
                        pin_out_o[i] <= pwm_steer_pkg::SHUT_LEVEL;
                    end else begin
                        pin_out_o[i] <= pwm_delayed
                            ^ pin_invert(unit_reg.output_polarity_select, i);
                    end
                end else begin
                    pin_out_o[i] <= port_data_i[i];
                end
            end
        end
    end

    // read mux, unmapped reads give zero
    always_comb begin
        rd_data = 32'h0000_0000;
        if (wb_adr_i == pwm_steer_pkg::OFF_RESTART) begin
            rd_data[7:0] = rd_reg;
        end else if (wb_adr_i == pwm_steer_pkg::OFF_STEER) begin
            rd_data[4:0] = steer_reg;
        end else if (wb_adr_i == pwm_steer_pkg::OFF_UNIT) begin
            rd_data[7:0] = unit_reg;
        end else if (wb_adr_i == pwm_steer_pkg::OFF_STATUS) begin
            rd_data[pwm_steer_pkg::STAT_EVENT_BIT] = shutdown_event_status;
            rd_data[pwm_steer_pkg::STAT_LEVEL_BIT] = sd_sync_reg;
            rd_data[pwm_steer_pkg::STAT_RUN_BIT] = run_reg;
        end else if (wb_adr_i == pwm_steer_pkg::OFF_DIR) begin
            rd_data[3:0] = dir_reg;
        end
    end

    // bus answer one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    event_set_a: assert property (sd_sync_reg |=> shutdown_event_status)
        else $error("shutdown flag not set during condition");
    auto_clear_a: assert property (shutdown_event_status && rd_reg.auto_restart_enable
        && !sd_sync_reg |=> !shutdown_event_status)
        else $error("auto restart did not clear flag");
    hold_shut_a: assert property (shutdown_event_status && !rd_reg.auto_restart_enable
        && !wr_hit(wb_wr, wb_adr_i, pwm_steer_pkg::OFF_STATUS)
        |=> shutdown_event_status ##1 !run_reg)
        else $error("shutdown released without software");
    restart_period_a: assert property ($rose(run_reg) |-> $past(period_start_i)
        && !$past(shutdown_event_status))
        else $error("output resumed outside period start");
    sync_update_a: assert property ($changed(steer_eff_reg) && $past(steer_reg.steer_update_sync)
        |-> $past(period_start_i))
        else $error("synced steering changed mid period");
    nosync_update_a: assert property ($rose(pending_reg) && !steer_reg.steer_update_sync
        && !wb_wr |-> ##[1:4] !pending_reg)
        else $error("unsynced steering update not applied");
    upper_zero_a: assert property (wb_ack_o && $past(wb_adr_i) == pwm_steer_pkg::OFF_STEER
        && !$past(wb_we_i) |-> wb_dat_o[7:5] == 3'h0)
        else $error("unimplemented steering bits read nonzero");
    port_pass_a: assert property (!steer_active |=> pin_out_o == $past(port_data_i))
        else $error("port data not passed without steering");
    shut_pin_a: assert property (steer_active && steer_eff_reg[0] && !run_reg
        |=> pin_out_o[0] == pwm_steer_pkg::SHUT_LEVEL)
        else $error("steered pin not forced in shutdown");
    polarity_a: assert property (steer_active && steer_eff_reg[1] && run_reg
        |=> pin_out_o[1] == ($past(pwm_delayed) ^ $past(unit_reg.output_polarity_select[0])))
        else $error("steered pin polarity wrong");
    dir_gate_a: assert property ($past(dir_reg[2]) |-> pin_oe_n_o[2])
        else $error("driver enabled with input direction");
endmodule // pwm_steering_restart_control
`default_nettype wire

// file: pwm_steering_restart_control_tb_top.sv
`default_nettype none
module pwm_steering_restart_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0] op;
        logic [7:0] adr;
        logic [7:0] dat;
        logic [7:0] exp;
    } row_t;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, q;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, raw = 1'b1, per = 1'b0, shut = 1'b0;
    logic [3:0] port = 4'h0, pin_out_o, pin_oe_n_o, gate;
    int num_errors = 0, n_compared = 0;
    // ops: 0 read and compare, 1 write, 2 compare gates, 3 compare enables
    row_t rows [0:30] = '{
        '{2'h0, 8'h00, 8'h00, 8'h00}, '{2'h0, 8'h04, 8'h00, 8'h01},
        '{2'h0, 8'h08, 8'h00, 8'h00}, '{2'h0, 8'h0C, 8'h00, 8'h04},
        '{2'h0, 8'h10, 8'h00, 8'h0F}, '{2'h0, 8'h14, 8'h00, 8'h00},
        '{2'h1, 8'h04, 8'hFF, 8'h00}, '{2'h0, 8'h04, 8'h00, 8'h1F},
        '{2'h1, 8'h00, 8'hFF, 8'h00}, '{2'h0, 8'h00, 8'h00, 8'hFF},
        '{2'h1, 8'h00, 8'h00, 8'h00}, '{2'h1, 8'h04, 8'h05, 8'h00},
        '{2'h1, 8'h10, 8'h00, 8'h00}, '{2'h3, 8'h00, 8'h00, 8'h00},
        '{2'h2, 8'h00, 8'h00, 8'h00}, '{2'h1, 8'h08, 8'h0C, 8'h00},
        '{2'h2, 8'h00, 8'h00, 8'h05}, '{2'h1, 8'h04, 8'h0F, 8'h00},
        '{2'h2, 8'h00, 8'h00, 8'h0F}, '{2'h1, 8'h08, 8'h0E, 8'h00},
        '{2'h2, 8'h00, 8'h00, 8'h0A}, '{2'h1, 8'h08, 8'h0D, 8'h00},
        '{2'h2, 8'h00, 8'h00, 8'h05}, '{2'h1, 8'h08, 8'h4C, 8'h00},
        '{2'h2, 8'h00, 8'h00, 8'h00}, '{2'h1, 8'h08, 8'h0C, 8'h00},
        '{2'h1, 8'h04, 8'h01, 8'h00}, '{2'h2, 8'h00, 8'h00, 8'h01},
        '{2'h1, 8'h10, 8'h0E, 8'h00}, '{2'h3, 8'h00, 8'h00, 8'h0E},
        '{2'h1, 8'h10, 8'h00, 8'h00}};

    pwm_steering_restart_control dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_raw_i(raw), .period_start_i(per),
        .shutdown_i(shut), .port_data_i(port), .pin_out_o(pin_out_o),
        .pin_oe_n_o(pin_oe_n_o));
    switch_driver_model drv (.clk_i(clk_i), .pin_out_i(pin_out_o),
        .pin_oe_n_i(pin_oe_n_o), .gate_o(gate));

    // clock at 100 MHz
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle, held until ack is seen at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            test_done();
        end
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic pins(input int n, input logic [3:0] e);
        repeat (n) @(posedge clk_i);
        #1;
        chk({28'h0, gate}, {28'h0, e});
        // hand the next stimulus back to a rising edge
        @(posedge clk_i);
    endtask

    task automatic pulse();
        @(posedge clk_i);
        per <= 1'b1;
        @(posedge clk_i);
        per <= 1'b0;
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        test_done();
    end

    // main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            case (rows[i].op)
                2'h0: begin
                    wb(1'b0, rows[i].adr, 8'h00);
                    chk(q, {24'h0, rows[i].exp});
                end
                2'h1: wb(1'b1, rows[i].adr, rows[i].dat);
                2'h2: pins(12, rows[i].exp[3:0]);
                default: begin
                    #1;
                    chk({28'h0, pin_oe_n_o}, {24'h0, rows[i].exp});
                end
            endcase
        end
        // synchronised steering waits for the period start
        wb(1'b1, 8'h04, 8'h1F);
        pins(12, 4'h1);
        pulse();
        pins(3, 4'hF);
        wb(1'b1, 8'h04, 8'h01);
        pins(6, 4'h1);
        // dead band on the rising edge only
        raw <= 1'b0;
        wb(1'b1, 8'h00, 8'h03);
        pins(4, 4'h0);
        raw <= 1'b1;
        pins(7, 4'h0);
        pins(9, 4'h1);
        raw <= 1'b0;
        pins(2, 4'h0);
        wb(1'b1, 8'h00, 8'h00);
        raw <= 1'b1;
        pins(3, 4'h1);
        // shutdown with software restart, pin b left to the port
        port <= 4'h2;
        shut <= 1'b1;
        pins(8, 4'h2);
        shut <= 1'b0;
        pins(8, 4'h2);
        wb(1'b0, 8'h0C, 8'h00);
        chk(q & 32'h1, 32'h1);
        wb(1'b1, 8'h0C, 8'h00);
        pins(8, 4'h2);
        pulse();
        pins(3, 4'h3);
        // shutdown with automatic restart
        wb(1'b1, 8'h00, 8'h80);
        shut <= 1'b1;
        pins(16, 4'h2);
        wb(1'b0, 8'h0C, 8'h00);
        chk(q & 32'h1, 32'h1);
        shut <= 1'b0;
        pins(6, 4'h2);
        wb(1'b0, 8'h0C, 8'h00);
        chk(q & 32'h1, 32'h0);
        pulse();
        pins(3, 4'h3);
        // reset in mid-run restores defaults
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk({28'h0, pin_oe_n_o}, 32'hF);
        wb(1'b0, 8'h04, 8'h00);
        chk(q, 32'h1);
        test_done();
    end
endmodule // pwm_steering_restart_control_tb_top
`default_nettype wire

// file: switch_driver_model.sv
`default_nettype none
// gate drivers of the power switches: they see a pin only while it is driven
module switch_driver_model (
    input wire logic clk_i,
    input wire logic [3:0] pin_out_i,
    input wire logic [3:0] pin_oe_n_i,
    output logic [3:0] gate_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] last_reg;
    // remember the last driven level of each pin
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 4; i++) begin
            if (!pin_oe_n_i[i]) last_reg[i] <= pin_out_i[i];
        end
    end
    // a released pin floats, so show the inverse of its last level
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            gate_o[i] = pin_oe_n_i[i] ? ~last_reg[i] : pin_out_i[i];
        end
    end
endmodule // switch_driver_model
`default_nettype wire
